// ===== hw/ocu_params.svh
// Offsets, field positions, keys and reset values of the oscillator control unit
`ifndef OCU_PARAMS_SVH
`define OCU_PARAMS_SVH
`define OCU_OFS_CTRL    8'h00
`define OCU_OFS_TUNE    8'h04
`define OCU_OFS_CFG     8'h08
`define OCU_KEY_LO1     8'h46
`define OCU_KEY_LO2     8'h57
`define OCU_KEY_HI1     8'h78
`define OCU_KEY_HI2     8'h9A
`define OCU_CUR_LSB     12
`define OCU_NEW_LSB     8
`define OCU_POST_LSB    6
`define OCU_LOCK_BIT    5
`define OCU_CF_BIT      3
`define OCU_SOSC_BIT    1
`define OCU_REQ_BIT     0
`define OCU_MON_LSB     14
`define OCU_POR_LSB     8
`define OCU_PRI_LSB     0
`define OCU_CTRL_MASK   16'h7FEB
`define OCU_TUNE_MASK   16'h000F
`define OCU_CFG_MASK    24'h00C71F
`define OCU_GRP_FRC     3'h1
`define OCU_GRP_RST     3'h0
`define OCU_POST_RST    2'h0
`define OCU_TUNE_RST    4'h0
`define OCU_RESP_OKAY   2'h0
`define OCU_RESP_SLVERR 2'h2
`endif

// ===== hw/ocu_pkg.sv
// Types shared by the oscillator control unit
package ocu_pkg;
  // Unlock state of one byte of the control register
  typedef enum logic [1:0] {
    OCU_LK_IDLE = 2'b00,
    OCU_LK_KEY  = 2'b01,
    OCU_LK_OPEN = 2'b10
  } ocu_lock_e;
  // One register write taken from the bus
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } ocu_wr_s;
  // Implemented fields of the configuration word
  typedef struct packed {
    logic [1:0] mon;
    logic [2:0] por;
    logic [4:0] pri;
  } ocu_cfg_s;
endpackage : ocu_pkg

// ===== hw/ocu_axil_slave.sv
// AXI4-Lite slave front end for the oscillator control unit
`timescale 1ns/10ps
`include "ocu_params.svh"
module ocu_axil_slave import ocu_pkg::*; (
  input  wire logic        clk_i,     // System clock
  input  wire logic        reset_i,   // Synchronous reset
  input  wire logic [7:0]  awaddr_i,  // Write address
  input  wire logic        awvalid_i, // Write address valid
  output logic             awready_o, // Write address ready
  input  wire logic [31:0] wdata_i,   // Write data
  input  wire logic [3:0]  wstrb_i,   // Byte enables
  input  wire logic        wvalid_i,  // Write data valid
  output logic             wready_o,  // Write data ready
  output logic [1:0]       bresp_o,   // Write response
  output logic             bvalid_o,  // Write response valid
  input  wire logic        bready_i,  // Write response ready
  input  wire logic [7:0]  araddr_i,  // Read address
  input  wire logic        arvalid_i, // Read address valid
  output logic             arready_o, // Read address ready
  output logic [31:0]      rdata_o,   // Read data
  output logic [1:0]       rresp_o,   // Read response
  output logic             rvalid_o,  // Read data valid
  input  wire logic        rready_i,  // Read data ready
  output ocu_wr_s          wr_o,      // Write to the register file
  output logic             wr_en_o,   // Write strobe, one cycle
  input  wire logic        wr_err_i,  // Write address unmapped
  output logic [7:0]       rd_addr_o, // Read address to the register file
  output logic             rd_en_o,   // Read strobe, one cycle
  input  wire logic [31:0] rd_data_i, // Read data from the register file
  input  wire logic        rd_err_i   // Read address unmapped
);
  logic        aw_full_ff, w_full_ff, ar_full_ff;
  logic        bvalid_ff, rvalid_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  ocu_wr_s     wr_ff;
  logic        aw_take, w_take, ar_take, issue;
  logic [7:0]  araddr_ff;

  // Handshakes; address and data are taken in either order
  assign aw_take   = awvalid_i & ~aw_full_ff;
  assign w_take    = wvalid_i & ~w_full_ff;
  assign ar_take   = arvalid_i & ~ar_full_ff & ~rvalid_ff;
  assign issue     = aw_full_ff & w_full_ff & ~bvalid_ff;
  assign awready_o = ~aw_full_ff;
  assign wready_o  = ~w_full_ff;
  assign arready_o = ~ar_full_ff & ~rvalid_ff;
  assign wr_o      = wr_ff;
  assign wr_en_o   = issue;
  assign rd_addr_o = araddr_ff;
  assign rd_en_o   = ar_full_ff;
  assign bvalid_o  = bvalid_ff;
  assign bresp_o   = bresp_ff;
  assign rvalid_o  = rvalid_ff;
  assign rresp_o   = rresp_ff;
  assign rdata_o   = rdata_ff;

  // Write path: hold address and data until both are present
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `OCU_RESP_OKAY;
      wr_ff      <= '0;
    end else begin
      if (aw_take) wr_ff.addr <= awaddr_i;
      if (w_take) begin
        wr_ff.data <= wdata_i;
        wr_ff.strb <= wstrb_i;
      end
      aw_full_ff <= issue ? 1'b0 : (aw_full_ff | aw_take);
      w_full_ff  <= issue ? 1'b0 : (w_full_ff | w_take);
      if (issue) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_err_i ? `OCU_RESP_SLVERR : `OCU_RESP_OKAY;
      end else if (bready_i) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read path: data sampled one cycle after the address is taken
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ar_full_ff <= 1'b0;
      araddr_ff  <= 8'h00;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= `OCU_RESP_OKAY;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      if (ar_take) araddr_ff <= araddr_i;
      ar_full_ff <= ar_take;
      if (ar_full_ff) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_data_i;
        rresp_ff  <= rd_err_i ? `OCU_RESP_SLVERR : `OCU_RESP_OKAY;
      end else if (rready_i) begin
        rvalid_ff <= 1'b0;
      end
    end
  end
endmodule : ocu_axil_slave

// ===== hw/ocu_top.sv
// Oscillator control unit: guarded control register, tuning and configuration
// ***************************************************************************
// ***************************************************************************
`timescale 1ns/10ps
`include "ocu_params.svh"
module ocu_top import ocu_pkg::*; (
  input  wire logic        clk_i,          // System clock, 250 MHz
  input  wire logic        reset_i,        // Synchronous power-on/brown-out reset
  input  wire logic [7:0]  s_axi_awaddr,   // Write address
  input  wire logic        s_axi_awvalid,  // Write address valid
  output logic             s_axi_awready,  // Write address ready
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Byte enables
  input  wire logic        s_axi_wvalid,   // Write data valid
  output logic             s_axi_wready,   // Write data ready
  output logic [1:0]       s_axi_bresp,    // Write response
  output logic             s_axi_bvalid,   // Write response valid
  input  wire logic        s_axi_bready,   // Write response ready
  input  wire logic [7:0]  s_axi_araddr,   // Read address
  input  wire logic        s_axi_arvalid,  // Read address valid
  output logic             s_axi_arready,  // Read address ready
  output logic [31:0]      s_axi_rdata,    // Read data
  output logic [1:0]       s_axi_rresp,    // Read response
  output logic             s_axi_rvalid,   // Read data valid
  input  wire logic        s_axi_rready,   // Read data ready
  input  wire logic [23:0] cfg_word_i,     // Non-volatile configuration word
  input  wire logic        pll_lock_i,     // PLL lock level
  input  wire logic        clk_fail_i,     // Monitor saw the oscillator fail
  input  wire logic        switch_done_i,  // Clock switch finished
  output logic [2:0]       cur_grp_o,      // Active oscillator group
  output logic [4:0]       pri_sel_o,      // Primary variant / PLL source
  output logic             switch_req_o,   // Switch request to the switcher
  output logic [2:0]       new_grp_o,      // Target group of the switch
  output logic             monitor_en_o,   // Fail-safe monitor enabled
  output logic             clock_fail_o,   // Clock failure flag
  output logic             sosc_en_o,      // Secondary 32 kHz oscillator on
  output logic [3:0]       frc_tune_o,     // Fast RC trim
  output logic             post_en_o       // Postscaled clock enable pulse
);
  // ***************************************************************************
  // Functions
  // ***************************************************************************
  // Key sequencer for one byte; every bus access advances it
  function automatic ocu_lock_e lock_next(input ocu_lock_e st, input logic hit,
                                          input logic [7:0] b, input logic [7:0] k1,
                                          input logic [7:0] k2);
    ocu_lock_e r;
    r = OCU_LK_IDLE;
    case (st)
      OCU_LK_IDLE: r = (hit && b == k1) ? OCU_LK_KEY : OCU_LK_IDLE;
      OCU_LK_KEY: begin
        if (hit && b == k2)      r = OCU_LK_OPEN;
        else if (hit && b == k1) r = OCU_LK_KEY;
        else                     r = OCU_LK_IDLE;
      end
      default:     r = OCU_LK_IDLE;
    endcase
    return r;
  endfunction : lock_next

  // Terminal count of the postscaler
  function automatic logic [5:0] div_limit(input logic [1:0] sel);
    logic [5:0] r;
    r = 6'h00;
    case (sel)
      2'h1:    r = 6'h03;
      2'h2:    r = 6'h0F;
      2'h3:    r = 6'h3F;
      default: r = 6'h00;
    endcase
    return r;
  endfunction : div_limit

  // ***************************************************************************
  // Bus front end
  // ***************************************************************************
  ocu_wr_s     wr;
  logic        wr_en, rd_en, wr_err, rd_err;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;

  ocu_axil_slave u_bus (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .awaddr_i  (s_axi_awaddr),
    .awvalid_i (s_axi_awvalid),
    .awready_o (s_axi_awready),
    .wdata_i   (s_axi_wdata),
    .wstrb_i   (s_axi_wstrb),
    .wvalid_i  (s_axi_wvalid),
    .wready_o  (s_axi_wready),
    .bresp_o   (s_axi_bresp),
    .bvalid_o  (s_axi_bvalid),
    .bready_i  (s_axi_bready),
    .araddr_i  (s_axi_araddr),
    .arvalid_i (s_axi_arvalid),
    .arready_o (s_axi_arready),
    .rdata_o   (s_axi_rdata),
    .rresp_o   (s_axi_rresp),
    .rvalid_o  (s_axi_rvalid),
    .rready_i  (s_axi_rready),
    .wr_o      (wr),
    .wr_en_o   (wr_en),
    .wr_err_i  (wr_err),
    .rd_addr_o (rd_addr),
    .rd_en_o   (rd_en),
    .rd_data_i (rd_data),
    .rd_err_i  (rd_err)
  );

  // ***************************************************************************
  // Pin synchronisers
  // ***************************************************************************
  logic [26:0] sync1_ff, sync2_ff;
  logic        fail_q_ff, done_q_ff;

  // Two stages before use; the configuration pins are static but still cross
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync1_ff  <= 27'h0;
      sync2_ff  <= 27'h0;
      fail_q_ff <= 1'b0;
      done_q_ff <= 1'b0;
    end else begin
      sync1_ff  <= {clk_fail_i, switch_done_i, pll_lock_i, cfg_word_i};
      sync2_ff  <= sync1_ff;
      fail_q_ff <= sync2_ff[26];
      done_q_ff <= sync2_ff[25];
    end
  end

  // ***************************************************************************
  // State
  // ***************************************************************************
  ocu_lock_e  lk_lo_ff, lk_hi_ff;
  ocu_cfg_s   cfg_ff;
  logic [1:0] init_ff;
  logic [2:0] cur_ff, new_ff;
  logic [1:0] post_ff;
  logic [3:0] tune_ff;
  logic [5:0] div_cnt_ff;
  logic       req_ff, cf_ff, sosc_ff, lock_ff, div_en_ff, mon_en_ff;

  // Event and decode terms
  logic       any_txn, hit_ctrl, hit_tune, hit_cfg, hit_lo, hit_hi;
  logic       lo_we, hi_we, init_done, init_load, sw_en, fsm_en;
  logic       fail_evt, done_evt;
  logic [5:0] div_lim;
  assign any_txn   = wr_en | rd_en;
  assign hit_ctrl  = wr_en && wr.addr == `OCU_OFS_CTRL;
  assign hit_tune  = wr_en && wr.addr == `OCU_OFS_TUNE;
  assign hit_cfg   = wr_en && wr.addr == `OCU_OFS_CFG;
  assign hit_lo    = hit_ctrl & wr.strb[0];
  assign hit_hi    = hit_ctrl & wr.strb[1];
  assign lo_we     = hit_lo && lk_lo_ff == OCU_LK_OPEN;
  assign hi_we     = hit_hi && lk_hi_ff == OCU_LK_OPEN;
  assign init_load = init_ff == 2'h2;
  assign init_done = init_ff == 2'h3;
  assign sw_en     = ~cfg_ff.mon[1];
  assign fsm_en    = cfg_ff.mon == 2'h0;
  assign fail_evt  = sync2_ff[26] & ~fail_q_ff & fsm_en & init_done;
  assign done_evt  = sync2_ff[25] & ~done_q_ff & req_ff;
  assign div_lim   = div_limit(post_ff);

  // Key sequencers; any access other than the next key, a repeated first key or the write closes them
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lk_lo_ff <= OCU_LK_IDLE;
      lk_hi_ff <= OCU_LK_IDLE;
    end else if (any_txn) begin
      lk_lo_ff <= lock_next(lk_lo_ff, hit_lo, wr.data[7:0],
                            `OCU_KEY_LO1, `OCU_KEY_LO2);
      lk_hi_ff <= lock_next(lk_hi_ff, hit_hi, wr.data[15:8],
                            `OCU_KEY_HI1, `OCU_KEY_HI2);
    end
  end

  // Configuration capture after reset release, once the pins have settled
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      init_ff   <= 2'h0;
      cfg_ff    <= '0;
      mon_en_ff <= 1'b0;
    end else begin
      if (!init_done) init_ff <= init_ff + 2'h1;
      if (init_load) begin
        cfg_ff.mon <= sync2_ff[`OCU_MON_LSB +: 2];
        cfg_ff.por <= sync2_ff[`OCU_POR_LSB +: 3];
        cfg_ff.pri <= sync2_ff[`OCU_PRI_LSB +: 5];
        mon_en_ff  <= sync2_ff[`OCU_MON_LSB +: 2] == 2'h0;
      end
    end
  end

  // Oscillator groups; failure beats a completed switch
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cur_ff <= `OCU_GRP_RST;
      new_ff <= `OCU_GRP_RST;
    end else if (init_load) begin
      cur_ff <= sync2_ff[`OCU_POR_LSB +: 3];
      new_ff <= sync2_ff[`OCU_POR_LSB +: 3];
    end else if (init_done) begin
      if (hi_we) new_ff <= wr.data[`OCU_NEW_LSB +: 3];
      if (!sw_en)        cur_ff <= cfg_ff.por;
      else if (fail_evt) cur_ff <= `OCU_GRP_FRC;
      else if (done_evt) cur_ff <= new_ff;
    end
  end

  // Request and failure flag; hardware wins over a software write: a failure sets the flag, events or disabled switching clear the request
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      req_ff <= 1'b0;
      cf_ff  <= 1'b0;
    end else begin
      if (!sw_en || fail_evt || done_evt) req_ff <= 1'b0;
      else if (lo_we) req_ff <= wr.data[`OCU_REQ_BIT];
      if (fail_evt) cf_ff <= 1'b1;
      else if (lo_we && !wr.data[`OCU_CF_BIT]) cf_ff <= 1'b0;
    end
  end

  // Plain control fields and lock status
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      post_ff <= `OCU_POST_RST;
      sosc_ff <= 1'b0;
      tune_ff <= `OCU_TUNE_RST;
      lock_ff <= 1'b0;
    end else begin
      lock_ff <= sync2_ff[24];
      if (lo_we) begin
        post_ff <= wr.data[`OCU_POST_LSB +: 2];
        sosc_ff <= wr.data[`OCU_SOSC_BIT];
      end
      if (hit_tune && wr.strb[0]) tune_ff <= wr.data[3:0];
    end
  end

  // Postscaler; a slower rate is an enable pulse, never a second clock
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_cnt_ff <= 6'h00;
      div_en_ff  <= 1'b0;
    end else begin
      div_cnt_ff <= (div_cnt_ff >= div_lim) ? 6'h00 : div_cnt_ff + 6'h01;
      div_en_ff  <= div_cnt_ff >= div_lim;
    end
  end

  // ***************************************************************************
  // Read decode
  // ***************************************************************************
  logic [15:0] ctrl_rd, tune_rd;
  logic [23:0] cfg_rd;
  assign ctrl_rd = {1'b0, cur_ff, 1'b0, new_ff, post_ff, lock_ff, 1'b0,
                    cf_ff, 1'b0, sosc_ff, req_ff} & `OCU_CTRL_MASK;
  assign tune_rd = {12'h000, tune_ff} & `OCU_TUNE_MASK;
  assign cfg_rd  = {8'h00, cfg_ff.mon, 3'h0, cfg_ff.por, 3'h0,
                    cfg_ff.pri} & `OCU_CFG_MASK;
  // Address decoding; the configuration word is read-only over the bus
  assign rd_data = (rd_addr == `OCU_OFS_CTRL) ? {16'h0000, ctrl_rd} :
                   (rd_addr == `OCU_OFS_TUNE) ? {16'h0000, tune_rd} :
                   (rd_addr == `OCU_OFS_CFG)  ? {8'h00, cfg_rd} : 32'h0000_0000;
  assign rd_err  = rd_addr != `OCU_OFS_CTRL && rd_addr != `OCU_OFS_TUNE &&
                   rd_addr != `OCU_OFS_CFG;
  assign wr_err  = ~(hit_ctrl | hit_tune | hit_cfg);

  // Outputs, each straight from a flop
  assign cur_grp_o    = cur_ff;
  assign pri_sel_o    = cfg_ff.pri;
  assign switch_req_o = req_ff;
  assign new_grp_o    = new_ff;
  assign monitor_en_o = mon_en_ff;
  assign clock_fail_o = cf_ff;
  assign sosc_en_o    = sosc_ff;
  assign frc_tune_o   = tune_ff;
  assign post_en_o    = div_en_ff;

  // ***************************************************************************
  // Assertions
  // ***************************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // The window may stay open for many idle cycles, so check how it opened
  AST_LO_WINDOW: assert property ($rose(lk_lo_ff == OCU_LK_OPEN) |->
                                  $past(lk_lo_ff) == OCU_LK_KEY &&
                                  $past(hit_lo && wr.data[7:0] == `OCU_KEY_LO2))
    else $error("low byte opened without key pair");
  AST_HI_WINDOW: assert property ($rose(lk_hi_ff == OCU_LK_OPEN) |->
                                  $past(lk_hi_ff) == OCU_LK_KEY &&
                                  $past(hit_hi && wr.data[15:8] == `OCU_KEY_HI2))
    else $error("high byte opened without key pair");
  AST_ONE_SHOT: assert property ((lk_lo_ff == OCU_LK_OPEN && any_txn)
                                 |=> lk_lo_ff != OCU_LK_OPEN)
    else $error("low byte window outlived one access");
  AST_FAIL_FRC: assert property ((fail_evt && sw_en) |=> cur_ff == `OCU_GRP_FRC)
    else $error("failure did not select fast RC");
  AST_FAIL_REQ: assert property (fail_evt |=> !req_ff && cf_ff)
    else $error("failure left request set or flag clear");
  AST_DONE_COPY: assert property ((done_evt && sw_en && !fail_evt)
                                  |=> cur_ff == $past(new_ff) && !req_ff)
    else $error("switch completion did not copy group");
  AST_MODE_OFF: assert property ((init_done && !sw_en)
                                 |=> !req_ff && cur_ff == cfg_ff.por)
    else $error("disabled switching still acts");
  AST_POST64: assert property ((div_en_ff && post_ff == 2'h3 && $stable(post_ff))
                               |=> !div_en_ff [*8])
    else $error("postscaler pulse too early");
  AST_RD_ZERO: assert property ((rd_en && rd_addr == `OCU_OFS_CTRL)
                                |=> (s_axi_rdata & ~32'h0000_7FEB) == 32'h0)
    else $error("unimplemented control bits read nonzero");

  COV_UNLOCK: cover property (lk_lo_ff == OCU_LK_KEY ##[1:8] lo_we);
  COV_SWITCH: cover property (req_ff ##[1:50] done_evt);
  COV_FAIL:   cover property (fail_evt ##1 cf_ff);
endmodule : ocu_top

// ===== verification/test_oscillator_control_unlock.sv
// Self-checking testbench of the oscillator control unit
`timescale 1ns/10ps
`include "ocu_params.svh"
module test_oscillator_control_unlock import ocu_pkg::*; ;
  // ******************************
  // Signals and the unit under test
  // ******************************
  logic        clk_i, reset_i, awvalid, wvalid, bready, arvalid, rready, lock, fail, done;
  logic        awready, wready, bvalid, arready, rvalid, req_o, mon_o, cf_o, sosc_o, post_o;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb, tune_o;
  logic [23:0] cfg;
  logic [31:0] wdata, rdata, d, v;
  logic [1:0]  bresp, rresp, r, post;
  logic [2:0]  cur_o, new_o, cur, nw, g;
  logic [4:0]  pri_o;
  logic        sosc, req, cf;
  int          bad_count, compares, n;

  ocu_top dut (
    .clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cfg_word_i(cfg), .pll_lock_i(lock), .clk_fail_i(fail), .switch_done_i(done),
    .cur_grp_o(cur_o), .pri_sel_o(pri_o), .switch_req_o(req_o), .new_grp_o(new_o),
    .monitor_en_o(mon_o), .clock_fail_o(cf_o), .sosc_en_o(sosc_o), .frc_tune_o(tune_o),
    .post_en_o(post_o)
  );

  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Watchdog, far beyond the fewer than a thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    conclude();
  end

  // ******************************
  // Bus cycles and comparisons
  // ******************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Address and data offered together, each dropped once taken
  // Waits as long as it takes; only the watchdog ends a hung transfer
  task automatic wr(input logic [7:0] a, input logic [31:0] val, input logic [3:0] s);
    @(posedge clk_i);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, val, s, 3'b111};
    do begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask : rd

  // Control register against the shadow copy kept here
  task automatic cc();
    rd(`OCU_OFS_CTRL);
    chk(d, {17'h0, cur, 1'b0, nw, post, lock, 1'b0, cf, 1'b0, sosc, req});
  endtask : cc

  // Keyed writes to the low and the high byte
  task automatic wlo(input logic [7:0] b);
    wr(`OCU_OFS_CTRL, 32'h46, 4'h1);
    wr(`OCU_OFS_CTRL, 32'h57, 4'h1);
    wr(`OCU_OFS_CTRL, {24'h0, b}, 4'h1);
    {post, sosc, req} = {b[7:6], b[1], b[0]};
    cf = cf & b[3];
  endtask : wlo

  task automatic whi(input logic [2:0] grp);
    wr(`OCU_OFS_CTRL, 32'h7800, 4'h2);
    wr(`OCU_OFS_CTRL, 32'h9A00, 4'h2);
    wr(`OCU_OFS_CTRL, {21'h0, grp, 8'h0}, 4'h2);
    nw = grp;
  endtask : whi

  // Event pulse, long enough to pass the input synchronisers
  task automatic ev(input bit is_fail);
    @(posedge clk_i);
    if (is_fail) fail <= 1'b1;
    else done <= 1'b1;
    repeat (4) @(posedge clk_i);
    {fail, done} <= 2'b00;
    repeat (8) @(posedge clk_i);
  endtask : ev

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // ******************************
  // Tests
  // ******************************
  initial begin
    void'($urandom(51334));
    {awvalid, wvalid, bready, arvalid, rready, fail, done, reset_i} = 8'h01;
    {awaddr, araddr, wstrb, wdata} = '0;
    cfg = 24'($urandom()) & 24'hFF3FFF; // Mode 00, junk in unused bits
    lock = 1'($urandom());
    {post, sosc, req, cf, cur, nw} = {5'h0, cfg[10:8], cfg[10:8]};
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk({mon_o, pri_o, cur_o, new_o}, {1'b1, cfg[4:0], cur, nw});
    cc();
    rd(`OCU_OFS_TUNE);
    chk(d, 32'h0);
    wr(`OCU_OFS_CFG, 32'hFFFFFFFF, 4'hF);
    chk(r, `OCU_RESP_OKAY);
    rd(`OCU_OFS_CFG);
    chk(d, {8'h0, cfg & 24'h00C71F});
    rd(8'h0C);
    chk({r, d[29:0]}, {`OCU_RESP_SLVERR, 30'h0});
    wr(8'h0C, 32'h1, 4'hF);
    chk(r, `OCU_RESP_SLVERR);
    $display("test reset values done");
    wr(`OCU_OFS_CTRL, 32'hFFFF, 4'h3);
    cc();
    wr(`OCU_OFS_CTRL, 32'h46, 4'h1);
    wr(`OCU_OFS_CTRL, 32'h57, 4'h1);
    rd(`OCU_OFS_TUNE);
    wr(`OCU_OFS_CTRL, 32'hFF, 4'h1);
    cc();
    for (int p = 0; p < 4; p++) begin
      wlo({p[1:0], 4'h0, p[0], 1'b0});
      wr(`OCU_OFS_CTRL, 32'hFF, 4'h1);
      cc();
      chk(sosc_o, p[0]);
      n = 0;
      repeat (64) begin
        @(posedge clk_i);
        n += post_o;
      end
      chk(n, 64 >> (2 * p));
    end
    $display("test unlock and postscaler done");
    g = 3'($urandom());
    whi(g);
    chk(new_o, g);
    wlo(8'h01);
    chk(req_o, 1'b1);
    ev(1'b0);
    {cur, req} = {nw, 1'b0};
    cc();
    wlo(8'h01);
    wlo(8'h00);
    chk(req_o, 1'b0);
    wlo(8'h01);
    ev(1'b1);
    {cur, cf, req} = {3'h1, 2'b10};
    cc();
    chk({cf_o, req_o, cur_o}, {2'b10, 3'h1});
    wlo(8'h08);
    cc();
    wlo(8'h00);
    lock <= ~lock;
    repeat (4) @(posedge clk_i);
    cc();
    $display("test switch and failure done");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'h7 : (i == 1) ? 32'h8 : $urandom();
      wr(`OCU_OFS_TUNE, v, 4'hF);
      rd(`OCU_OFS_TUNE);
      chk(d, v & 32'hF);
      chk(tune_o, v[3:0]);
    end
    $display("test tuning done");
    // Mid-run resets into modes 01, 10 and 11: monitor off, switching only in 01
    for (int m = 1; m < 4; m++) begin
      g = 3'($urandom());
      reset_i <= 1'b1;
      cfg <= {8'($urandom()), m[1:0], 3'($urandom()), g, 8'($urandom())};
      {post, sosc, req, cf, cur, nw} = {5'h0, g, g};
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk({mon_o, pri_o, cur_o}, {1'b0, cfg[4:0], g});
      rd(`OCU_OFS_CFG);
      chk(d, {8'h0, cfg & 24'h00C71F});
      cc();
      wlo(8'h01);
      req = (m == 1);
      cc();
      ev(1'b1);
      cc();
      ev(1'b0);
      req = 1'b0;
      cc();
      $display("test mode %0d done", m);
    end
    conclude();
  end
endmodule : test_oscillator_control_unlock
